// *** acs_pkg.sv ***
package acs_pkg;

  // Result word and serial framing
  localparam int DATA_W          = 16;             // Bits per result, MSB first
  localparam int BIT_CNT_W       = 5;              // Counts 0..16
  localparam logic [15:0] SHIFT_RST = 16'h0000;    // Shift register after reset

  // Clock and timing
  localparam int CLK_PERIOD_NS   = 4;              // System clock period
  localparam int CONVERT_START_N_TIME_NS    = 20000;          // Conversion (busy) time
  localparam int CONVERT_START_N_CYCLES     = (CONVERT_START_N_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_PHASE_NS    = 100;            // One phase of the internal bit clock
  localparam int BIT_PHASE_CYCLES = (BIT_PHASE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    BIT_PHASE_NS / CLK_PERIOD_NS;

  // Result buffer
  localparam int FIFO_DEPTH      = 16;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic convert_start_n_n;   // convert_start_n
    logic cs_n;     // Chip select, active low
    logic ext_sel;  // clock_source_select, high = external bit clock
    logic sclk;     // serial_bit_clock as seen on the pin
  } acs_pins_t;
  localparam acs_pins_t PINS_RST = 4'hc;           // Idle pin levels

  // Result word carried from the converter core
  typedef struct packed {
    logic [DATA_W-1:0] code;  // Two's complement result
  } acs_result_t;

  // Conversion sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONVERT_START_N = 3'b010,
    ST_DONE = 3'b100
  } acs_state_t;

endpackage

// *** acs_chip_select.sv ***
// What this block does
// - Chip select high disables data and clock
// - External clock ignored while chip select high
// - Disable anytime without disturbing conversion sequencing
// - A convert-start falling edge while idle starts conversion
// - Internal transfer still runs with outputs off
// - Bit clock driven only in internal mode
// - Internal mode: previous result, 16 bits, idle low
// - Busy low over the whole internal transmission
// - External rising edge starts, bits MSB first
`timescale 1ns/1ps
`default_nettype none

module acs_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];   // Storage
  logic [AW-1:0] wr_ptr_r;    // Next slot to fill
  logic [AW-1:0] rd_ptr_r;    // Oldest slot
  logic [AW:0]   count_r;     // Words held
  logic [AW:0]   count_nxt;
  logic          push;
  logic          pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];

  // Occupancy after this cycle
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Pointers, count and a registered ready so the source sees full honestly
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      in_ready_o <= 1'b1;
    end else begin
      count_r    <= count_nxt;
      in_ready_o <= (count_nxt != (AW+1)'(D));
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
endmodule

module acs_chip_select import acs_pkg::*; #(
  parameter int CONVERT_START_N_CYCLES_P = CONVERT_START_N_CYCLES  // Shorten for simulation
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Control pins from the host
  input  wire logic        convert_start_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        clock_source_select_i,
  // Serial bit clock pin, two-way
  input  wire logic        serial_bit_clock_i,
  output logic             serial_bit_clock_o,
  output logic             serial_bit_clock_oe_o,
  // Serial data pin, three-state
  output logic             serial_data_o,
  output logic             serial_data_oe_o,
  // Status pin
  output logic             busy_n_o,
  // Results from the converter core
  input  wire logic        result_valid_i,
  output logic             result_ready_o,
  input  wire acs_result_t result_i
);

  acs_pins_t pin_s1_r;          // First stage, read only by second
  acs_pins_t pin_s2_r;
  acs_pins_t pin_s3_r;
  acs_pins_t pin_r;             // Settled pin levels
  logic      convert_start_n_prev_r;       // For the convert-start edge
  logic      sclk_prev_r;       // For external clock edges
  logic      convert_start_n_fall;
  logic      ext_rise;

  acs_state_t        state_r;      // Conversion sequencer
  logic [15:0]       convert_start_n_cnt_r;   // Cycles left in conversion
  logic [DATA_W-1:0] shift_r;      // Output shift register
  logic [BIT_CNT_W-1:0] ext_idx_r; // Bits sent in external mode
  logic              tx_active_r;  // Internal transfer in progress
  logic [BIT_CNT_W-1:0] tx_bit_r;  // Bit being sent internally
  logic [1:0]        tx_phase_r;   // Setup, high, low
  logic [7:0]        tx_div_r;     // Phase timer
  logic              fifo_valid;
  acs_result_t       fifo_data;
  logic              fifo_pop;
  logic              take_result;

  // Pins cross into the clock domain; a change counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= PINS_RST;
      pin_s2_r <= PINS_RST;
      pin_s3_r <= PINS_RST;
      pin_r    <= PINS_RST;
    end else begin
      pin_s1_r <= {convert_start_n_i, cs_n_i, clock_source_select_i, serial_bit_clock_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_r[i] <= pin_s3_r[i];
        end
      end
    end
  end

  // Edge history on settled levels
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      convert_start_n_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
    end else begin
      convert_start_n_prev_r <= pin_r.convert_start_n_n;
      sclk_prev_r <= pin_r.sclk;
    end
  end

  assign convert_start_n_fall = convert_start_n_prev_r && !pin_r.convert_start_n_n;
  // External clock only counts with chip select low
  assign ext_rise  = pin_r.ext_sel && !pin_r.cs_n && pin_r.sclk && !sclk_prev_r;

  // Results queue here until a conversion ends; the core is stalled when full
  acs_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (result_valid_i),
    .in_ready_o  (result_ready_o),
    .in_data_i   (result_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // A word is consumed at each conversion end, even if the host blocks the update
  assign fifo_pop    = (state_r == ST_DONE);
  // Update only if the external clock is quiet or gated off at the end
  assign take_result = fifo_pop && fifo_valid &&
                       (!pin_r.ext_sel || !pin_r.sclk || pin_r.cs_n);

  // Conversion sequencer; chip select plays no part here
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r    <= ST_IDLE;
      convert_start_n_cnt_r <= '0;
      busy_n_o   <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (convert_start_n_fall) begin
            state_r    <= ST_CONVERT_START_N;
            convert_start_n_cnt_r <= 16'(CONVERT_START_N_CYCLES_P - 1);
            busy_n_o   <= 1'b0;
          end
        end
        ST_CONVERT_START_N: begin
          if (convert_start_n_cnt_r == '0) begin
            state_r <= ST_DONE;
          end else begin
            convert_start_n_cnt_r <= convert_start_n_cnt_r - 1'b1;
          end
        end
        ST_DONE: begin
          state_r  <= ST_IDLE;
          busy_n_o <= 1'b1;
        end
        default: begin
          state_r  <= ST_IDLE;
          busy_n_o <= 1'b1;
        end
      endcase
    end
  end

  // Shift register holds the last accepted result
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_r <= SHIFT_RST;
    end else if (take_result) begin
      shift_r <= fifo_data.code;
    end
  end

  // Internal transfer of the previous result during the new conversion
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_active_r <= 1'b0;
      tx_bit_r    <= '0;
      tx_phase_r  <= 2'h0;
      tx_div_r    <= '0;
    end else if (!tx_active_r) begin
      // Runs whatever chip select does, so the word is lost if disabled
      if (state_r == ST_IDLE && convert_start_n_fall && !pin_r.ext_sel) begin
        tx_active_r <= 1'b1;
        tx_bit_r    <= '0;
        tx_phase_r  <= 2'h0;
        tx_div_r    <= 8'(BIT_PHASE_CYCLES - 1);
      end
    end else if (tx_div_r != '0) begin
      tx_div_r <= tx_div_r - 1'b1;
    end else begin
      tx_div_r <= 8'(BIT_PHASE_CYCLES - 1);
      if (tx_phase_r != 2'h2) begin
        tx_phase_r <= tx_phase_r + 1'b1;
      end else begin
        tx_phase_r <= 2'h0;
        if (tx_bit_r == BIT_CNT_W'(DATA_W - 1)) begin
          tx_active_r <= 1'b0;
        end else begin
          tx_bit_r <= tx_bit_r + 1'b1;
        end
      end
    end
  end

  // External-mode bit counter, rewound when a new result lands
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_idx_r <= '0;
    end else if (take_result) begin
      ext_idx_r <= '0;
    end else if (ext_rise && ext_idx_r != BIT_CNT_W'(DATA_W)) begin
      ext_idx_r <= ext_idx_r + 1'b1;
    end
  end

  // Data and clock levels; both rest low between internal transfers, external data holds its last bit
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serial_data_o      <= 1'b0;
      serial_bit_clock_o <= 1'b0;
    end else if (!pin_r.ext_sel) begin
      serial_data_o      <= tx_active_r && shift_r[DATA_W-1-tx_bit_r];
      serial_bit_clock_o <= tx_active_r && (tx_phase_r == 2'h1);
    end else begin
      serial_bit_clock_o <= 1'b0;
      // Next bit appears on the rising edge, host samples just before the next rise
      if (ext_rise && ext_idx_r != BIT_CNT_W'(DATA_W)) begin
        serial_data_o <= shift_r[DATA_W-1-ext_idx_r];
      end
    end
  end

  // Enables follow chip select at any moment; released pins float
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serial_data_oe_o      <= 1'b0;
      serial_bit_clock_oe_o <= 1'b0;
    end else begin
      serial_data_oe_o      <= !pin_r.cs_n;
      serial_bit_clock_oe_o <= !pin_r.cs_n && !pin_r.ext_sel;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_cs_off;
    pin_r.cs_n |=> !serial_data_oe_o && !serial_bit_clock_oe_o;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("outputs enabled with cs high");

  property p_ext_no_drive;
    pin_r.ext_sel |=> !serial_bit_clock_oe_o;
  endproperty
  a_ext_no_drive: assert property (p_ext_no_drive) else $error("clock driven in ext mode");

  property p_gate;
    pin_r.ext_sel && pin_r.cs_n && !take_result |=> $stable(ext_idx_r);
  endproperty
  a_gate: assert property (p_gate) else $error("ext clock not gated");

  property p_start;
    state_r == ST_IDLE && convert_start_n_fall |=> !busy_n_o && state_r == ST_CONVERT_START_N;
  endproperty
  a_start: assert property (p_start) else $error("convert start missed");

  property p_cs_free;
    state_r == ST_IDLE && convert_start_n_fall && !pin_r.ext_sel |=> tx_active_r ##1 tx_active_r;
  endproperty
  a_cs_free: assert property (p_cs_free) else $error("internal transfer skipped");

  property p_busy_frame;
    serial_bit_clock_o |-> !busy_n_o;
  endproperty
  a_busy_frame: assert property (p_busy_frame) else $error("clock outside busy");

  property p_idle_low;
    !tx_active_r && !pin_r.ext_sel |=> !serial_data_o && !serial_bit_clock_o;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle lines not low");

  property p_drop;
    fifo_pop && pin_r.ext_sel && pin_r.sclk && !pin_r.cs_n |=> $stable(shift_r);
  endproperty
  a_drop: assert property (p_drop) else $error("shift updated under clock");

  property p_ext_bit;
    ext_rise && ext_idx_r == '0 && !take_result |=> serial_data_o == shift_r[DATA_W-1];
  endproperty
  a_ext_bit: assert property (p_ext_bit) else $error("first bit not msb");

  property p_disable_any;
    state_r == ST_CONVERT_START_N && pin_r.cs_n && convert_start_n_cnt_r != '0 |=> state_r == ST_CONVERT_START_N;
  endproperty
  a_disable_any: assert property (p_disable_any) else $error("cs disturbed sequencing");

endmodule

`default_nettype wire

// *** acs_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module acs_host (
  // Pins as the host sees them
  input  wire logic cs_n_i,
  input  wire logic busy_n_i,
  input  wire logic ext_i,
  input  wire logic clk_line_i,
  input  wire logic data_line_i,
  // Bit clock that the host drives in external mode
  output logic      host_clk_o,
  output logic      host_clk_en_o
);
  logic [15:0] int_word;  // Word gathered on the device clock
  int          int_bits;  // Bits gathered since the bench cleared it

  // The host drives the clock pin only while the device takes it as input
  assign host_clk_en_o = ext_i;
  // Clock stands still low outside frames
  initial host_clk_o = 1'b0;
  initial int_word = 16'h0000;
  initial int_bits = 0;

  // Busy low is the frame sync; a deselected host does not listen
  always @(posedge clk_line_i) begin
    if (!ext_i && !cs_n_i && !busy_n_i) begin
      int_word = {int_word[14:0], data_line_i};
      int_bits = int_bits + 1;
    end
  end

  // Rising edge moves a bit out; sample late, just before the next rise
  task automatic ext_read(input int n, input bit hold, output logic [15:0] w);
    w = 16'h0000;
    #7;
    for (int i = 0; i < n; i++) begin
      host_clk_o = 1'b1;
      #24;
      // Holding high on the last bit breaks the load rule on purpose
      if (!(hold && i == n - 1)) host_clk_o = 1'b0;
      #20;
      w = {w[14:0], data_line_i};
      #4;
    end
  endtask

  // Ends a deliberate hold
  task automatic release_clk();
    host_clk_o = 1'b0;
    // Stay low long enough for the synchroniser to see the fall
    #24;
  endtask
endmodule

`default_nettype wire

// *** adc_chip_select_output_gating_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module adc_chip_select_output_gating_tb import acs_pkg::*;;
  localparam int CONVERT_START_N_P = 1300;  // Room for a whole internal frame
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        convert_start_n_n = 1'b1;    // Convert start, active low
  logic        cs_n = 1'b1;      // Chip select, active low
  logic        ext = 1'b0;       // External bit clock chosen
  logic        flip = 1'b0;      // Pattern on undriven lines
  logic        res_valid = 1'b0;
  acs_result_t res = '0;
  logic        bclk_o, bclk_oe, data_o, data_oe, busy_n, res_ready;
  logic        host_clk, host_en;
  logic        bclk_line, data_line;
  int          failures = 0;
  int          n_tests = 0;

  always #2 sys_clk = ~sys_clk;
  // Undriven lines change every cycle so no stale value passes
  always @(posedge sys_clk) flip <= ~flip;
  assign bclk_line = bclk_oe ? bclk_o : (host_en ? host_clk : flip);
  assign data_line = data_oe ? data_o : flip;

  acs_chip_select #(.CONVERT_START_N_CYCLES_P(CONVERT_START_N_P)) dut (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .convert_start_n_i(convert_start_n_n),
    .cs_n_i(cs_n), .clock_source_select_i(ext), .serial_bit_clock_i(bclk_line),
    .serial_bit_clock_o(bclk_o), .serial_bit_clock_oe_o(bclk_oe),
    .serial_data_o(data_o), .serial_data_oe_o(data_oe), .busy_n_o(busy_n),
    .result_valid_i(res_valid), .result_ready_o(res_ready), .result_i(res));

  acs_host host (
    .cs_n_i(cs_n), .busy_n_i(busy_n), .ext_i(ext), .clk_line_i(bclk_line),
    .data_line_i(data_line), .host_clk_o(host_clk), .host_clk_en_o(host_en));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Pins change just after an edge and then settle for ten cycles
  task automatic setup(input logic c, input logic e);
    @(posedge sys_clk);
    #1;
    cs_n = c;
    ext = e;
    repeat (10) @(posedge sys_clk);
  endtask

  // Held until ready is seen high at an edge
  task automatic push(input logic [15:0] w);
    @(posedge sys_clk);
    #1;
    res_valid = 1'b1;
    res.code = w;
    // Ready only moves on edges, so its settled value is what the next edge takes
    for (int k = 0; k < 50 && res_ready !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
    res_valid = 1'b0;
  endtask

  // One conversion; busy length and disabled outputs judged throughout
  task automatic convert();
    int lo;
    int bad;
    lo = 0;
    bad = 0;
    @(posedge sys_clk);
    #1;
    convert_start_n_n = 1'b0;
    for (int k = 0; k < 12 && busy_n !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    check("busy start", 16'h0000, {15'h0000, busy_n});
    convert_start_n_n = 1'b1;
    while (busy_n === 1'b0 && lo < 2000) begin
      if ((cs_n && (data_oe !== 1'b0 || bclk_oe !== 1'b0)) || (ext && bclk_oe !== 1'b0)) bad++;
      @(posedge sys_clk);
      #1;
      lo++;
    end
    check("busy length", 16'(CONVERT_START_N_P + 1), 16'(lo));
    check("outputs off", 16'h0000, 16'(bad));
    if (!ext) check("idle lines", 16'h0000, {14'h0000, bclk_o, data_o});
  endtask

  // Previous result goes out during the next conversion
  task automatic t_internal();
    setup(1'b0, 1'b0);
    push(16'h8001);
    host.int_bits = 0;
    convert();
    check("int bits", 16'h0010, 16'(host.int_bits));
    check("int word", SHIFT_RST, host.int_word);
    push(16'h7ffe);
    host.int_bits = 0;
    convert();
    check("int bits", 16'h0010, 16'(host.int_bits));
    check("int word", 16'h8001, host.int_word);
    $display("test internal done");
  endtask

  // A deselected conversion still shifts, so its word is lost; its own result shows on the next one
  task automatic t_cs_high();
    setup(1'b1, 1'b0);
    push(16'h1234);
    convert();
    setup(1'b0, 1'b0);
    host.int_bits = 0;
    convert();
    check("after hidden", 16'h1234, host.int_word);
    $display("test cs high done");
  endtask

  // Fill the buffer until refused, then drain it in order by slow reads
  task automatic t_fifo();
    logic [15:0] w;
    setup(1'b0, 1'b1);
    for (int i = 0; i < 16; i++) push(16'h0f0f + 16'(i) * 16'h1357);
    repeat (2) @(posedge sys_clk);
    #1;
    check("fifo full", 16'h0000, {15'h0000, res_ready});
    for (int i = 0; i < 16; i++) begin
      convert();
      if (i == 2) begin
        // Clock edges while deselected must not move the word
        setup(1'b1, 1'b1);
        host.ext_read(8, 1'b0, w);
        setup(1'b0, 1'b1);
      end
      host.ext_read(16, 1'b0, w);
      check("ext word", 16'h0f0f + 16'(i) * 16'h1357, w);
    end
    check("fifo drained", 16'h0001, {15'h0000, res_ready});
    $display("test fifo done");
  endtask

  // Clock held high over the load keeps the old word and drops the new
  task automatic t_drop();
    logic [15:0] w1;
    logic [15:0] w2;
    setup(1'b0, 1'b1);
    push(16'hc3a5);
    convert();
    host.ext_read(9, 1'b1, w1);
    push(16'h5a5a);
    convert();
    host.release_clk();
    host.ext_read(7, 1'b0, w2);
    check("kept word", 16'hc3a5, {w1[8:0], w2[6:0]});
    $display("test drop done");
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    check("reset outs", 16'h0030, {10'h000, busy_n, res_ready, data_oe, bclk_oe, data_o, bclk_o});
    #1;
    sys_rst = 1'b0;
    t_internal();
    t_cs_high();
    t_fifo();
    t_drop();
    test_done();
  end

  // Cuts a hang short well past the expected run length
  initial begin
    #300000;
    failures++;
    test_done();
  end
endmodule

`default_nettype wire
